// ===== inc/lprc_defines.svh
// lprc_defines.svh: offsets, field positions, reset values of the risc core
`ifndef LPRC_DEFINES_SVH
`define LPRC_DEFINES_SVH
// ==========================================================================
// instruction word fields
`define LPRC_INSTR_W 22
`define LPRC_OP_MSB 21
`define LPRC_OP_LSB 17
`define LPRC_ALT_BIT 16
`define LPRC_DST_MSB 11
`define LPRC_DST_LSB 8
`define LPRC_SRC_MSB 7
`define LPRC_SRC_LSB 4
`define LPRC_MODE_MSB 2
`define LPRC_MODE_LSB 0
`define LPRC_DMA_MSB 15
`define LPRC_DMA_LSB 8
`define LPRC_NUM_MODES 8
// ==========================================================================
// internal register indices
`define LPRC_R3 4'h3
`define LPRC_I0H 4'h4
`define LPRC_IPH 4'hC
`define LPRC_IPL 4'hD
`define LPRC_STAT 4'hE
`define LPRC_ACC 4'hF
// ==========================================================================
// status word bit positions
`define LPRC_IE2 7
`define LPRC_IE1 6
`define LPRC_GIE 5
`define LPRC_IN2 4
`define LPRC_IN1 3
`define LPRC_IN0 2
`define LPRC_EV1 1
`define LPRC_EV0 0
// ==========================================================================
// reset values and debug port addresses
`define LPRC_STAT_RESET 8'h00
`define LPRC_PC_RESET 16'h0000
`define LPRC_IRQ_VECTOR 16'h0001
`define LPRC_DBG_PCL 5'h10
`define LPRC_DBG_PCH 5'h11
`define LPRC_DBG_FLAGS 5'h12
`define LPRC_DBG_CTRL 5'h13
`endif

// ===== inc/lprc_pkg.sv
// lprc_pkg: types shared by the risc core modules
package lprc_pkg;
  // ========================================================================
  // opcodes of the 5-bit major field
  typedef enum logic [4:0] {
    LPRC_NOP, LPRC_JMP, LPRC_JZ, LPRC_JNZ, LPRC_JC, LPRC_JNC, LPRC_JV, LPRC_JNV,
    LPRC_CALL, LPRC_CALLS, LPRC_RET, LPRC_RETS, LPRC_RETI, LPRC_PUSH, LPRC_POP,
    LPRC_MOVI, LPRC_MOVR, LPRC_MOVST, LPRC_MOVDI, LPRC_CMVD, LPRC_CMVS,
    LPRC_SHL, LPRC_SHLC, LPRC_SHR, LPRC_SHRC, LPRC_SHRA, LPRC_ADD, LPRC_SUBD,
    LPRC_HALT
  } lprc_op_t;
  // run state, one-hot
  typedef enum logic [1:0] {
    LPRC_RUN = 2'b01,
    LPRC_SLEEP = 2'b10
  } lprc_state_t;
  // alu functions
  typedef enum logic [2:0] {
    LPRC_A_PASS, LPRC_A_SHL, LPRC_A_SHLC, LPRC_A_SHR, LPRC_A_SHRC, LPRC_A_SHRA,
    LPRC_A_ADD, LPRC_A_SUB
  } lprc_alu_op_t;
endpackage

// ===== inc/lprc_dp_if.sv
// lprc_dp_if: datapath bundle between core, alu and address unit
`timescale 1ns/10ps
interface lprc_dp_if;
  import lprc_pkg::*;
  lprc_alu_op_t alu_op;
  logic [7:0] x;
  logic [7:0] y;
  logic cin;
  logic [7:0] res;
  logic cout;
  logic vout;
  logic [2:0] mode;
  logic [3:0][15:0] idx;
  logic [7:0] off;
  logic [15:0] eaddr;
  modport core (output alu_op, x, y, cin, mode, idx, off, input res, cout, vout, eaddr);
  modport alu (input alu_op, x, y, cin, output res, cout, vout);
  modport agu (input mode, idx, off, output eaddr);
endinterface // lprc_dp_if

// ===== hdl/lprc_alu.sv
// lprc_alu: shifts, moves and add/subtract with carry and overflow
`timescale 1ns/10ps
module lprc_alu
(
  // datapath
  lprc_dp_if.alu dp
);
  import lprc_pkg::*;
  logic [8:0] wide;

  // ========================================================================
  // result and flags
  always_comb
  begin
    wide = 9'h000;
    dp.res = dp.x;
    dp.cout = dp.cin;
    dp.vout = 1'h0;
    unique case (dp.alu_op)
      LPRC_A_PASS: ;
      LPRC_A_SHL, LPRC_A_SHLC:
      begin
        dp.res = {dp.x[6:0], (dp.alu_op == LPRC_A_SHLC) ? dp.cin : 1'h0};
        dp.cout = dp.x[7];
        dp.vout = dp.x[7] ^ dp.x[6];
      end
      LPRC_A_SHR:
      begin
        dp.res = {1'h0, dp.x[7:1]};
        dp.cout = dp.x[0];
      end
      LPRC_A_SHRC:
      begin
        dp.res = {dp.cin, dp.x[7:1]};
        dp.cout = dp.x[0];
      end
      LPRC_A_SHRA:
      begin
        dp.res = {dp.x[7], dp.x[7:1]};
        dp.cout = dp.x[0];
      end
      LPRC_A_ADD:
      begin
        wide = {1'h0, dp.y} + {1'h0, dp.x};
        dp.res = wide[7:0];
        dp.cout = wide[8];
        dp.vout = (dp.x[7] == dp.y[7]) && (wide[7] != dp.x[7]);
      end
      LPRC_A_SUB:
      begin
        wide = {1'h0, dp.x} - {1'h0, dp.y};
        dp.res = wide[7:0];
        dp.cout = ~wide[8];
        dp.vout = (dp.x[7] != dp.y[7]) && (wide[7] != dp.x[7]);
      end
    endcase
  end
endmodule // lprc_alu

// ===== hdl/lprc_agu.sv
// lprc_agu: data memory address for the eight addressing modes
`timescale 1ns/10ps
module lprc_agu
(
  // datapath
  lprc_dp_if.agu dp
);
  import lprc_pkg::*;
  logic [15:0] base;

  // ========================================================================
  // index select, optional offset add
  always_comb
  begin
    base = dp.idx[dp.mode[1:0]];
    dp.eaddr = dp.mode[2] ? base + {8'h00, dp.off} : base;
  end
endmodule // lprc_agu

// ===== hdl/lprc_core.sv
// lprc_core: single-cycle 8-bit risc core datapath with debug register port
`timescale 1ns/10ps
`include "lprc_defines.svh"
module lprc_core
#(
  parameter int STACK_DEPTH = 8,
  parameter logic [15:0] IRQ_VECTOR = `LPRC_IRQ_VECTOR
)
(
  // clock, reset, enable
  input wire logic CLOCK,
  input wire logic NRST,
  input wire logic CE,
  // program memory
  output logic [15:0] PM_ADDR,
  input wire logic [`LPRC_INSTR_W-1:0] PM_INSTR,
  // data memory
  output logic [15:0] DM_RADDR,
  input wire logic [7:0] DM_RDATA,
  output logic [15:0] DM_WADDR,
  output logic [7:0] DM_WDATA,
  output logic DM_WE,
  // interrupt and event requests
  input wire logic IRQ_LOW,
  input wire logic IRQ_MID,
  input wire logic IRQ_HIGH,
  input wire logic EVT_LOW,
  input wire logic EVT_HIGH,
  output logic SLEEPING,
  // debug register port
  input wire logic [4:0] DBG_ADDR,
  input wire logic [7:0] DBG_WDATA,
  input wire logic DBG_WR,
  input wire logic DBG_RD,
  output logic [7:0] DBG_RDATA
);
  import lprc_pkg::*;

  // ========================================================================
  // state of the core
  typedef struct packed {
    lprc_state_t state;
    logic [15:0] pc;
    logic [15:0][7:0] regs;
    logic z;
    logic c;
    logic v;
    logic [STACK_DEPTH-1:0][15:0] stack;
    logic hold;
    logic dm_we;
    logic [15:0] dm_waddr;
    logic [7:0] dm_wdata;
    logic [7:0] dbg_rdata;
  } lprc_core_t;

  localparam lprc_core_t RST_STATE = '{state: LPRC_RUN, pc: `LPRC_PC_RESET, default: '0};

  lprc_core_t s;
  lprc_core_t next_s;
  lprc_dp_if dp ();
  lprc_op_t op;
  logic alt;
  logic [3:0] dst;
  logic [3:0] src;
  logic [7:0] imm8;
  logic [15:0] ip;
  logic [15:0] target;
  logic [15:0] pc_inc;
  logic [15:0] push_val;
  logic [7:0] dm_rd;
  logic [7:0] src_val;
  logic [7:0] stat;
  logic irq_req;
  logic irq_take;
  logic ev_wake;
  logic [7:0] stat_set;
  logic [STACK_DEPTH-1:0][15:0] stack_dn;
  logic [STACK_DEPTH-1:0][15:0] stack_up;

  // ========================================================================
  // parameter check
  if (STACK_DEPTH < 2) begin : g_bad_depth
    $error("stack depth must be at least two");
  end

  // ========================================================================
  // instruction field decode
  assign op = lprc_op_t'(PM_INSTR[`LPRC_OP_MSB:`LPRC_OP_LSB]);
  assign alt = PM_INSTR[`LPRC_ALT_BIT];
  assign dst = PM_INSTR[`LPRC_DST_MSB:`LPRC_DST_LSB];
  assign src = PM_INSTR[`LPRC_SRC_MSB:`LPRC_SRC_LSB];
  assign imm8 = PM_INSTR[7:0];
  assign ip = {s.regs[`LPRC_IPH], s.regs[`LPRC_IPL]};
  assign target = alt ? ip : PM_INSTR[15:0];
  assign pc_inc = s.pc + 16'h0001;

  // posted write forwarded to a read of the same address
  assign dm_rd = (s.dm_we && s.dm_waddr == dp.eaddr) ? s.dm_wdata : DM_RDATA;
  assign src_val = alt ? dm_rd : s.regs[src];

  // ========================================================================
  // interrupt and event view of the status word
  assign stat = s.regs[`LPRC_STAT];
  assign irq_req = (stat[`LPRC_IE2] & stat[`LPRC_IN2]) | (stat[`LPRC_IE1] & stat[`LPRC_IN1])
                   | stat[`LPRC_IN0];
  assign irq_take = stat[`LPRC_GIE] & irq_req & ~s.hold;
  assign ev_wake = stat[`LPRC_EV1] | stat[`LPRC_EV0];
  // request pulses, ordered low/mid/high to levels 2/1/0
  assign stat_set = {3'h0, IRQ_LOW, IRQ_MID, IRQ_HIGH, EVT_LOW, EVT_HIGH};

  // ========================================================================
  // datapath units
  assign dp.x = src_val;
  assign dp.y = s.regs[dst];
  assign dp.cin = s.c;
  assign dp.mode = PM_INSTR[`LPRC_MODE_MSB:`LPRC_MODE_LSB];
  assign dp.off = s.regs[`LPRC_R3];
  assign dp.alu_op = (op == LPRC_SHL) ? LPRC_A_SHL :
                     (op == LPRC_SHLC) ? LPRC_A_SHLC :
                     (op == LPRC_SHR) ? LPRC_A_SHR :
                     (op == LPRC_SHRC) ? LPRC_A_SHRC :
                     (op == LPRC_SHRA) ? LPRC_A_SHRA :
                     (op == LPRC_ADD) ? LPRC_A_ADD :
                     (op == LPRC_SUBD) ? LPRC_A_SUB : LPRC_A_PASS;

  lprc_alu u_alu (.dp(dp));
  lprc_agu u_agu (.dp(dp));

  // ========================================================================
  // stack shifted down for a push, up for a pop
  assign push_val = (op == LPRC_PUSH && !irq_take) ? ip : (irq_take ? s.pc : pc_inc);
  for (genvar i = 0; i < STACK_DEPTH; i++)
  begin : g_stack
    assign stack_dn[i] = (i == 0) ? push_val : s.stack[(i == 0) ? 0 : i - 1];
    // deepest entry keeps its value on a pop
    assign stack_up[i] = (i == STACK_DEPTH - 1) ? s.stack[i]
                         : s.stack[(i == STACK_DEPTH - 1) ? i : i + 1];
  end

  // ========================================================================
  // four data memory index pairs, high byte first
  for (genvar j = 0; j < 4; j++)
  begin : g_index
    assign dp.idx[j] = {s.regs[`LPRC_I0H + 4'(2 * j)],
                        s.regs[`LPRC_I0H + 4'(2 * j + 1)]};
  end

  // ========================================================================
  // next state: one instruction per clock
  always_comb
  begin
    next_s = s;
    next_s.dm_we = 1'h0;
    if (s.hold)
    begin
      next_s.pc = s.pc;
    end
    else if (irq_take)
    begin
      next_s.stack = stack_dn;
      next_s.pc = IRQ_VECTOR;
      next_s.regs[`LPRC_STAT][`LPRC_GIE] = 1'h0;
      next_s.state = LPRC_RUN;
    end
    else if (s.state == LPRC_SLEEP)
    begin
      if (irq_req || ev_wake)
        next_s.state = LPRC_RUN;
    end
    else
    begin
      next_s.pc = pc_inc;
      unique case (op)
        LPRC_JMP: next_s.pc = target;
        LPRC_JZ: next_s.pc = s.z ? target : pc_inc;
        LPRC_JNZ: next_s.pc = !s.z ? target : pc_inc;
        LPRC_JC: next_s.pc = s.c ? target : pc_inc;
        LPRC_JNC: next_s.pc = !s.c ? target : pc_inc;
        LPRC_JV: next_s.pc = s.v ? target : pc_inc;
        LPRC_JNV: next_s.pc = !s.v ? target : pc_inc;
        LPRC_CALL:
        begin
          next_s.stack = stack_dn;
          next_s.pc = target;
        end
        LPRC_CALLS:
        begin
          next_s.regs[`LPRC_IPH] = pc_inc[15:8];
          next_s.regs[`LPRC_IPL] = pc_inc[7:0];
          next_s.pc = target;
        end
        LPRC_RET, LPRC_RETI:
        begin
          next_s.pc = s.stack[0];
          next_s.stack = stack_up;
          if (op == LPRC_RETI)
            next_s.regs[`LPRC_STAT][`LPRC_GIE] = 1'h1;
        end
        LPRC_RETS: next_s.pc = ip;
        LPRC_PUSH: next_s.stack = stack_dn;
        LPRC_POP:
        begin
          next_s.regs[`LPRC_IPH] = s.stack[0][15:8];
          next_s.regs[`LPRC_IPL] = s.stack[0][7:0];
          next_s.stack = stack_up;
        end
        LPRC_MOVI, LPRC_MOVR:
        begin
          next_s.regs[`LPRC_ACC] = (op == LPRC_MOVI) ? imm8 : src_val;
          next_s.regs[dst] = (op == LPRC_MOVI) ? imm8 : src_val;
          next_s.z = ((op == LPRC_MOVI) ? imm8 : src_val) == 8'h00;
        end
        LPRC_MOVST, LPRC_MOVDI:
        begin
          next_s.dm_we = 1'h1;
          next_s.dm_waddr = (op == LPRC_MOVST) ? dp.eaddr
                            : {8'h00, PM_INSTR[`LPRC_DMA_MSB:`LPRC_DMA_LSB]};
          next_s.dm_wdata = (op == LPRC_MOVST) ? s.regs[dst] : imm8;
        end
        LPRC_CMVD, LPRC_CMVS:
        begin
          next_s.regs[`LPRC_ACC] = src_val;
          next_s.z = src_val == 8'h00;
          if (s.c == (op == LPRC_CMVS))
            next_s.regs[dst] = src_val;
        end
        LPRC_SHL, LPRC_SHLC, LPRC_SHR, LPRC_SHRC, LPRC_SHRA, LPRC_ADD, LPRC_SUBD:
        begin
          next_s.regs[`LPRC_ACC] = dp.res;
          next_s.regs[dst] = dp.res;
          next_s.z = dp.res == 8'h00;
          next_s.c = dp.cout;
          next_s.v = dp.vout;
        end
        LPRC_HALT: next_s.state = LPRC_SLEEP;
        default: ;
      endcase
    end
    // debug port writes land after the instruction
    if (DBG_WR)
    begin
      if (!DBG_ADDR[4])
        next_s.regs[DBG_ADDR[3:0]] = DBG_WDATA;
      else if (DBG_ADDR == `LPRC_DBG_PCL)
        next_s.pc[7:0] = DBG_WDATA;
      else if (DBG_ADDR == `LPRC_DBG_PCH)
        next_s.pc[15:8] = DBG_WDATA;
      else if (DBG_ADDR == `LPRC_DBG_FLAGS)
        {next_s.v, next_s.c, next_s.z} = DBG_WDATA[2:0];
      else if (DBG_ADDR == `LPRC_DBG_CTRL)
        next_s.hold = DBG_WDATA[0];
    end
    // request set wins over any clear in the same cycle
    next_s.regs[`LPRC_STAT] = next_s.regs[`LPRC_STAT] | stat_set;
    // debug port read data, one cycle later
    if (DBG_RD)
    begin
      if (!DBG_ADDR[4])
        next_s.dbg_rdata = s.regs[DBG_ADDR[3:0]];
      else if (DBG_ADDR == `LPRC_DBG_PCL)
        next_s.dbg_rdata = s.pc[7:0];
      else if (DBG_ADDR == `LPRC_DBG_PCH)
        next_s.dbg_rdata = s.pc[15:8];
      else if (DBG_ADDR == `LPRC_DBG_FLAGS)
        next_s.dbg_rdata = {5'h00, s.v, s.c, s.z};
      else if (DBG_ADDR == `LPRC_DBG_CTRL)
        next_s.dbg_rdata = {6'h00, s.state == LPRC_SLEEP, s.hold};
      else
        next_s.dbg_rdata = 8'h00;
    end
  end

  // ========================================================================
  // state register, frozen while the clock enable is low
  always_ff @(posedge CLOCK)
  begin
    if (!NRST)
      s <= RST_STATE;
    else if (CE)
      s <= next_s;
  end

  // outputs straight from state flip-flops, except DM_RADDR from the address unit
  assign PM_ADDR = s.pc;
  assign DM_RADDR = dp.eaddr;
  assign DM_WADDR = s.dm_waddr;
  assign DM_WDATA = s.dm_wdata;
  assign DM_WE = s.dm_we;
  assign SLEEPING = s.state[1];
  assign DBG_RDATA = s.dbg_rdata;

  // ========================================================================
  // checks
  default clocking cb @(posedge CLOCK); endclocking
  default disable iff (!NRST);
  logic go;
  assign go = CE && s.state == LPRC_RUN && !s.hold && !irq_take && !DBG_WR;

  jump_target_a: assert property (go && op == LPRC_JMP |=> s.pc == $past(target))
    else $error("jump did not load target");
  cond_skip_a: assert property (go && op == LPRC_JZ && !s.z |=> s.pc == $past(pc_inc))
    else $error("untaken jump did not advance");
  call_push_a: assert property (go && op == LPRC_CALL
    |=> s.stack[0] == $past(pc_inc) && s.stack[1] == $past(s.stack[0]))
    else $error("call did not push return address");
  ret_pop_a: assert property (go && op == LPRC_RET |=> s.pc == $past(s.stack[0]))
    else $error("return did not pop");
  reti_enable_a: assert property (go && op == LPRC_RETI |=> s.regs[`LPRC_STAT][`LPRC_GIE])
    else $error("interrupt return left global enable clear");
  calls_index_a: assert property (go && op == LPRC_CALLS |=> ip == $past(pc_inc))
    else $error("index call did not save return");
  zero_flag_a: assert property (go && (op == LPRC_MOVR || op == LPRC_SHL)
    |=> s.z == (s.regs[`LPRC_ACC] == 8'h00))
    else $error("zero flag wrong");
  shl_carry_a: assert property (go && op == LPRC_SHL
    |=> s.c == $past(src_val[7]) && !s.regs[`LPRC_ACC][0])
    else $error("left shift carry wrong");
  irq_latch_a: assert property (CE && IRQ_LOW |=> s.regs[`LPRC_STAT][`LPRC_IN2])
    else $error("low request lost");
  sleep_hold_a: assert property (CE && s.state == LPRC_SLEEP && !irq_req && !ev_wake
    && !DBG_WR && stat_set == 8'h00 |=> SLEEPING && $stable(s.pc))
    else $error("core left sleep without wake");
  cmvd_gate_a: assert property (go && op == LPRC_CMVD && s.c && dst != `LPRC_ACC
    && dst != `LPRC_STAT |=> s.regs[$past(dst)] == $past(s.regs[dst]))
    else $error("conditional move wrote on carry set");
  sub_borrow_a: assert property (go && op == LPRC_SUBD
    |=> s.c == ($past(src_val) >= $past(s.regs[dst])))
    else $error("subtract carry is not the inverted borrow");
  store_word_a: assert property (go && op == LPRC_MOVST
    |=> DM_WE && DM_WDATA == $past(s.regs[dst]) && $stable(s.regs[`LPRC_ACC]))
    else $error("memory move wrong or touched accumulator");

  call_seen_c: cover property (go && op == LPRC_CALL ##1 go && op == LPRC_RET);
  irq_seen_c: cover property (CE && irq_take);
  wake_seen_c: cover property (SLEEPING ##1 !SLEEPING);
  dbg_seen_c: cover property (DBG_RD ##1 DBG_WR);
endmodule // lprc_core

// ===== test/lprc_mem_model.sv
// lprc_mem_model: program and data memory facing the risc core
`timescale 1ns/10ps
`include "lprc_defines.svh"
module lprc_mem_model
(
  // clock
  input wire logic CLOCK,
  // program memory
  input wire logic [15:0] PM_ADDR,
  output logic [`LPRC_INSTR_W-1:0] PM_INSTR,
  // data memory
  input wire logic [15:0] DM_RADDR,
  output logic [7:0] DM_RDATA,
  input wire logic [15:0] DM_WADDR,
  input wire logic [7:0] DM_WDATA,
  input wire logic DM_WE
);
  logic [`LPRC_INSTR_W-1:0] rom [0:255];
  logic [7:0] ram [0:255];
  // ==========================================================================
  // same-cycle fetch and read; outside the loaded page only no-ops
  assign PM_INSTR = (PM_ADDR[15:8] == 8'h00) ? rom[PM_ADDR[7:0]] : '0;
  assign DM_RDATA = ram[DM_RADDR[7:0]];
  // posted write lands on the pulse
  always @(posedge CLOCK)
  begin
    if (DM_WE === 1'b1)
      ram[DM_WADDR[7:0]] <= DM_WDATA;
  end
endmodule // lprc_mem_model

// ===== test/lprc_core_bench.sv
// lprc_core_bench: self-checking bench for the risc core
`timescale 1ns/10ps
`include "lprc_defines.svh"
module lprc_core_bench;
  import lprc_pkg::*;
  logic CLOCK;
  logic NRST;
  logic [15:0] PM_ADDR;
  logic [21:0] PM_INSTR;
  logic [15:0] DM_RADDR;
  logic [7:0] DM_RDATA;
  logic [15:0] DM_WADDR;
  logic [7:0] DM_WDATA;
  logic DM_WE;
  logic SLEEPING;
  logic [4:0] DBG_ADDR;
  logic [7:0] DBG_WDATA;
  logic DBG_WR;
  logic DBG_RD;
  logic [7:0] DBG_RDATA;
  logic [4:0] req;
  logic pend;
  logic [7:0] exp_q [$];
  int num_errors = 0;
  int check_count = 0;
  int seed;
  logic [7:0] v, d, shl, sra, r1, r2, sum;
  logic [8:0] dif;
  logic CE;
  logic c;
  // ==========================================================================
  // design and memories
  lprc_core u_dut (.CLOCK(CLOCK), .NRST(NRST), .CE(CE), .PM_ADDR(PM_ADDR),
    .PM_INSTR(PM_INSTR), .DM_RADDR(DM_RADDR), .DM_RDATA(DM_RDATA), .DM_WADDR(DM_WADDR),
    .DM_WDATA(DM_WDATA), .DM_WE(DM_WE), .IRQ_LOW(req[0]), .IRQ_MID(req[1]),
    .IRQ_HIGH(req[2]), .EVT_LOW(req[3]), .EVT_HIGH(req[4]), .SLEEPING(SLEEPING),
    .DBG_ADDR(DBG_ADDR), .DBG_WDATA(DBG_WDATA), .DBG_WR(DBG_WR), .DBG_RD(DBG_RD),
    .DBG_RDATA(DBG_RDATA));
  lprc_mem_model u_mem (.CLOCK(CLOCK), .PM_ADDR(PM_ADDR), .PM_INSTR(PM_INSTR),
    .DM_RADDR(DM_RADDR), .DM_RDATA(DM_RDATA), .DM_WADDR(DM_WADDR), .DM_WDATA(DM_WDATA),
    .DM_WE(DM_WE));
  // 40 mhz clock
  initial
  begin
    CLOCK = 1'b0;
    forever #12.5 CLOCK = ~CLOCK;
  end
  // ==========================================================================
  // compare, verdict and bus tasks
  task automatic check8(input logic [7:0] got, input logic [7:0] exp);
    check_count++;
    if (got !== exp)
    begin
      num_errors++;
      $display("ERROR at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic check1(input logic got, input logic exp);
    check_count++;
    if (got !== exp)
    begin
      num_errors++;
      $display("ERROR at %0t: flag %h expected %h", $time, got, exp);
    end
  endtask
  task automatic tally_and_finish;
    $display("checks %0d errors %0d", check_count, num_errors);
    if (num_errors == 0 && check_count > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask
  task automatic dbg_wr(input logic [4:0] a, input logic [7:0] w);
    DBG_ADDR <= a;
    DBG_WDATA <= w;
    DBG_WR <= 1'b1;
    @(posedge CLOCK);
    DBG_WR <= 1'b0;
    @(posedge CLOCK);
  endtask
  task automatic dbg_rd(input logic [4:0] a, input logic [7:0] e);
    exp_q.push_back(e);
    DBG_ADDR <= a;
    DBG_RD <= 1'b1;
    @(posedge CLOCK);
    DBG_RD <= 1'b0;
    @(posedge CLOCK);
  endtask
  // one-cycle pulse on one interrupt or event request line
  task automatic pulse(input int b);
    req[b] <= 1'b1;
    @(posedge CLOCK);
    req[b] <= 1'b0;
    @(posedge CLOCK);
  endtask
  // bounded wait until the core sleeps at the given address
  task automatic wait_halt(input logic [15:0] pc);
    int k;
    for (k = 0; k < 300 && !(SLEEPING === 1'b1 && PM_ADDR === pc); k++)
      @(negedge CLOCK);
    check1(SLEEPING, 1'b1);
    @(posedge CLOCK);
  endtask
  function automatic logic [21:0] ins(input lprc_op_t op, input logic [15:0] w);
    return {op, 1'b0, w};
  endfunction
  // read data stand one cycle after the strobe
  always @(posedge CLOCK)
  begin
    if (pend === 1'b1)
      check8(DBG_RDATA, exp_q.pop_front());
    pend <= DBG_RD;
  end
  // hang guard
  initial
  begin
    repeat (4000) @(posedge CLOCK);
    num_errors++;
    tally_and_finish();
  end
  // ==========================================================================
  // main sequence
  initial
  begin
    seed = 32'h9d7e_a75a;
    v = 8'($random(seed));
    d = 8'($random(seed));
    NRST = 1'b0;
    CE = 1'b1;
    DBG_ADDR = 5'h00;
    DBG_WDATA = 8'h00;
    DBG_WR = 1'b0;
    DBG_RD = 1'b0;
    req = 5'h00;
    for (int i = 0; i < 256; i++)
      u_mem.rom[i] = '0;
    u_mem.ram[0] = d;
    u_mem.rom[8'h00] = ins(LPRC_JMP, 16'h0010);
    u_mem.rom[8'h01] = ins(LPRC_MOVI, 16'h0E00);
    u_mem.rom[8'h02] = ins(LPRC_RETI, 16'h0000);
    u_mem.rom[8'h10] = ins(LPRC_MOVI, {8'h00, v});
    u_mem.rom[8'h11] = ins(LPRC_SHL, 16'h0100);
    u_mem.rom[8'h12] = ins(LPRC_HALT, 16'h0000);
    u_mem.rom[8'h13] = ins(LPRC_MOVI, 16'h0E00);
    u_mem.rom[8'h14] = ins(LPRC_SHRA, 16'h0200);
    u_mem.rom[8'h15] = ins(LPRC_CMVD, 16'h0100);
    u_mem.rom[8'h16] = ins(LPRC_CMVS, 16'h0210);
    u_mem.rom[8'h17] = ins(LPRC_HALT, 16'h0000);
    u_mem.rom[8'h18] = ins(LPRC_MOVR, 16'h02E0);
    u_mem.rom[8'h19] = ins(LPRC_MOVI, 16'h0E00);
    u_mem.rom[8'h1A] = ins(LPRC_MOVI, 16'h0000);
    u_mem.rom[8'h1B] = ins(LPRC_JZ, 16'h001D);
    u_mem.rom[8'h1C] = ins(LPRC_MOVI, 16'h00EE);
    u_mem.rom[8'h1D] = ins(LPRC_CALL, 16'h0030);
    u_mem.rom[8'h1E] = ins(LPRC_HALT, 16'h0000);
    u_mem.rom[8'h1F] = {LPRC_MOVR, 1'b1, 16'h0100};
    u_mem.rom[8'h20] = ins(LPRC_ADD, 16'h0110);
    u_mem.rom[8'h21] = ins(LPRC_HALT, 16'h0000);
    u_mem.rom[8'h22] = ins(LPRC_HALT, 16'h0000);
    u_mem.rom[8'h30] = ins(LPRC_CALLS, 16'h0040);
    u_mem.rom[8'h31] = ins(LPRC_POP, 16'h0000);
    u_mem.rom[8'h32] = ins(LPRC_RET, 16'h0000);
    u_mem.rom[8'h40] = ins(LPRC_PUSH, 16'h0000);
    u_mem.rom[8'h41] = ins(LPRC_RETS, 16'h0000);
    u_mem.rom[8'h23] = ins(LPRC_MOVI, 16'h0E00);
    u_mem.rom[8'h24] = ins(LPRC_MOVI, 16'h0505);
    u_mem.rom[8'h25] = ins(LPRC_MOVDI, {8'h05, d});
    u_mem.rom[8'h26] = {LPRC_MOVR, 1'b1, 16'h0200};
    u_mem.rom[8'h27] = ins(LPRC_SUBD, 16'h0120);
    u_mem.rom[8'h28] = ins(LPRC_MOVST, 16'h0101);
    u_mem.rom[8'h2A] = {LPRC_MOVR, 1'b1, 16'h0301};
    u_mem.rom[8'h2B] = ins(LPRC_HALT, 16'h0000);
    shl = {v[6:0], 1'b0};
    sra = {v[7], v[7:1]};
    c = v[0];
    r1 = c ? shl : v;
    r2 = c ? r1 : sra;
    sum = {d[6:0], 1'b0};
    dif = {1'b0, d} - {1'b0, sum};
    repeat (20) @(posedge CLOCK);
    NRST <= 1'b1;
    // left shift, then wake by the low event
    wait_halt(16'h0013);
    dbg_rd(5'h01, shl);
    dbg_rd(5'h0F, shl);
    dbg_rd(`LPRC_DBG_FLAGS, {5'h00, v[7] ^ v[6], v[7], shl == 8'h00});
    dbg_rd(`LPRC_DBG_PCL, 8'h13);
    dbg_rd(`LPRC_DBG_PCH, 8'h00);
    pulse(3);
    // arithmetic shift and conditional moves
    wait_halt(16'h0018);
    dbg_rd(5'h01, r1);
    dbg_rd(5'h02, r2);
    dbg_rd(5'h0F, r1);
    dbg_rd(`LPRC_DBG_FLAGS, {6'h00, c, r1 == 8'h00});
    dbg_rd(5'h0E, 8'h00);
    pulse(4);
    // taken jump, calls, push and pop
    wait_halt(16'h001F);
    dbg_rd(5'h02, 8'h01);
    dbg_rd(5'h00, 8'h00);
    dbg_rd(5'h0D, 8'h31);
    dbg_rd(5'h0C, 8'h00);
    dbg_rd(`LPRC_DBG_FLAGS, {6'h00, c, 1'b1});
    dbg_rd(`LPRC_DBG_PCL, 8'h1F);
    // masked level-two request stays pending, level zero is taken
    dbg_wr(5'h0E, 8'h20);
    pulse(0);
    repeat (4) @(posedge CLOCK);
    dbg_rd(5'h0E, 8'h30);
    dbg_rd(`LPRC_DBG_CTRL, 8'h02);
    pulse(2);
    wait_halt(16'h0022);
    dbg_rd(5'h01, sum);
    dbg_rd(5'h0F, sum);
    dbg_rd(`LPRC_DBG_FLAGS, {5'h00, d[7] ^ d[6], d[7], sum == 8'h00});
    dbg_rd(5'h0E, 8'h20);
    // level-one request with its enable
    dbg_wr(5'h0E, 8'h60);
    pulse(1);
    wait_halt(16'h0023);
    dbg_rd(5'h0E, 8'h20);
    dbg_rd(`LPRC_DBG_PCL, 8'h23);
    // posted memory writes, forwarded read and subtract
    pulse(3);
    wait_halt(16'h002C);
    check8(u_mem.ram[8'h05], d);
    dbg_rd(5'h02, d);
    dbg_rd(5'h03, dif[7:0]);
    dbg_rd(5'h0F, dif[7:0]);
    dbg_rd(`LPRC_DBG_FLAGS, {5'h00, d[7] != sum[7] && dif[7] != d[7], ~dif[8],
      dif[7:0] == 8'h00});
    // frozen while the enable is low: a request is not latched
    CE <= 1'b0;
    pulse(4);
    CE <= 1'b1;
    dbg_rd(5'h0E, 8'h00);
    dbg_wr(`LPRC_DBG_CTRL, 8'h01);
    dbg_rd(`LPRC_DBG_CTRL, 8'h03);
    dbg_wr(`LPRC_DBG_CTRL, 8'h00);
    // unmapped debug address
    dbg_wr(5'h14, 8'hFF);
    dbg_rd(5'h14, 8'h00);
    repeat (3) @(posedge CLOCK);
    tally_and_finish();
  end
endmodule // lprc_core_bench
